// ---- rx_statistics_increment_pulses.sv ----
/*
  Receive statistics increment pulse generator. Watches the receive
  frame stream of the mac, classifies each frame when it ends and emits
  one-cycle increment pulses, one output per statistics class.
  Assumes the stream comes from mac logic on ref_clk (the receive mac
  clock), eight bytes per beat, first byte in bits 63:56, and that
  fcs checking is done upstream and reported with the last beat.
  Latency is one cycle: a pulse stands in the cycle after the
  edge that took the eop beat. Frames over 65535 bytes saturate
  the count and still read as oversized. There is no buffer, so
  back to back frames give back to back pulses and the counters
  must take one on every cycle. A frame with no eop stays open
  until the next start beat; no timeout closes it.
*/
//
// Functional notes
// R1 - pulse on good broadcast data frame
// R2 - pulse on errored unicast data frame
// R3 - pulse on good unicast data frame
// R4 - pulse on any good multicast frame
// R5 - pulse on any good broadcast frame
// R6 - pulse on any good unicast frame
// R7 - pulse on good pause frame
// R8 - pulse on any fcs error frame
// R9 - fcs pulse when mac sees error
// R10 - fcs pulse ignores client delivery filtering
// R11 - pulse on short frame with crc error
// R12 - pulse on oversized frame with crc error
// R13 - pulse on legal length frame, fcs error
// R14 - pulses always exported, counters or not
// R15 - pulses drive ports and counter increments
// R16 - all pulses on receive mac clock
// R17 - low in reset, one pulse per class
// R18 - consumer counts each high cycle once
`timescale 1ns/1ps

module rx_statistics_increment_pulses
    import rx_stat_pkg::*;
(
    // receive mac clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // frame stream from the mac
    input  wire logic                rxValid,
    input  wire logic                rxSop,
    input  wire logic                rxEop,
    input  wire logic [63:0]         rxData,
    input  wire logic [`EMPTY_W-1:0] rxEmpty,
    input  wire logic                rxFcsBad,
    // data classes
    output logic                     bcastDataGoodPulse,
    output logic                     ucastDataBadPulse,
    output logic                     ucastDataGoodPulse,
    // good frames by destination
    output logic                     mcastAnyGoodPulse,
    output logic                     bcastAnyGoodPulse,
    output logic                     ucastAnyGoodPulse,
    // control frames
    output logic                     pauseGoodPulse,
    // error and length classes
    output logic                     checksumBadPulse,
    output logic                     fragmentPulse,
    output logic                     jabberPulse,
    output logic                     rx_legal_length_bad_checksum_pulse
);

    // frame tracking state
    rx_state_t   stateReg;      // inside a frame or not
    rx_state_t   stateNext;
    byte_cnt_t   byteCntReg;    // bytes seen before this beat
    byte_cnt_t   byteCntNext;
    logic [1:0]  beatIdxReg;    // beat number, stops at two
    logic [1:0]  beatIdxNext;
    logic [47:0] destReg;       // captured destination address
    logic [47:0] destNext;
    logic [15:0] typeReg;       // captured length or type field
    logic [15:0] typeNext;
    logic [15:0] opcodeReg;     // captured control opcode
    logic [15:0] opcodeNext;

    // per-beat views of the frame
    logic        beatTaken;     // beat belongs to a frame
    logic        frameEnd;      // last beat of a frame
    logic [1:0]  curBeat;       // number of the present beat
    logic [3:0]  beatBytes;     // bytes carried this beat
    byte_cnt_t   baseCnt;       // count before this beat
    logic [16:0] cntSum;        // count with this beat, one spare bit
    byte_cnt_t   countNow;      // saturated count with this beat
    logic [47:0] destNow;       // destination as of this beat
    logic [15:0] typeNow;       // type field as of this beat
    logic [15:0] opcodeNow;     // opcode as of this beat

    // classification and pulse requests
    pulse_vec_t  classHits;     // classes that the frame matches
    pulse_vec_t  fireVec;       // requests to the pulse stages
    pulse_vec_t  pulseVec;      // registered pulses
    logic        legalBadHit;   // legal length with fcs error

    // a beat counts if it opens a frame or continues one; a stray
    // continuation beat outside a frame is dropped without a pulse
    always_comb begin
        beatTaken = rxValid && (rxSop || (stateReg == ST_FRAME));
        frameEnd  = beatTaken && rxEop;
        if (rxSop) begin
            // a start beat is always beat zero
            curBeat = 2'h0;
        end else begin
            // beats past the second share index two
            curBeat = beatIdxReg;
        end
    end

    // byte accounting; the empty count only applies to the last beat
    always_comb begin
        if (rxEop) begin
            // only the eop beat may be partly empty
            beatBytes = `BEAT_BYTES - {1'b0, rxEmpty};
        end else begin
            // full beat, all lanes carry data
            beatBytes = `BEAT_BYTES;
        end
        if (rxSop) begin
            // a start beat restarts the count
            baseCnt = '0;
        end else begin
            // go on from the stored count
            baseCnt = byteCntReg;
        end
        cntSum = {1'b0, baseCnt} + {13'h0, beatBytes};
        // saturate so a runaway frame still reads as oversized
        if (cntSum[16]) begin
            countNow = `CNT_SAT;
        end else begin
            // no carry, the sum fits
            countNow = cntSum[15:0];
        end
    end

    // header fields as they stand after this beat; the type field and
    // opcode sit in the second beat, so a frame ending there is
    // classified from the live data rather than from the registers
    always_comb begin
        if (curBeat == 2'h0) begin
            // first beat carries the destination
            destNow   = rxData[63:16];
        end else begin
            // held from the first beat
            destNow   = destReg;
        end
        case (curBeat)
            2'h0: begin
                // no type field seen yet
                typeNow   = 16'h0000;
                opcodeNow = 16'h0000;
            end
            2'h1: begin
                // type and opcode in the low half
                typeNow   = rxData[31:16];
                opcodeNow = rxData[15:0];
            end
            default: begin
                // later beats keep what beat one gave
                typeNow   = typeReg;
                opcodeNow = opcodeReg;
            end
        endcase
    end

    // next frame tracking values
    always_comb begin
        // hold by default, no latch inferred
        stateNext   = stateReg;
        byteCntNext = byteCntReg;
        beatIdxNext = beatIdxReg;
        destNext    = destReg;
        typeNext    = typeReg;
        opcodeNext  = opcodeReg;
        case (stateReg)
            ST_IDLE: begin
                // only a start beat opens a frame
                if (beatTaken && !rxEop) begin
                    stateNext = ST_FRAME;
                end
                // a one beat frame never leaves idle
            end
            ST_FRAME: begin
                // a new start abandons the open frame with no pulse
                if (frameEnd) begin
                    stateNext = ST_IDLE;
                end
                // no timeout: an open frame waits
            end
            default: begin
                // illegal state recovers to idle
                stateNext = ST_IDLE;
            end
        endcase
        // stray beats change nothing; a taken beat
        // stores its count and header view
        if (beatTaken) begin
            byteCntNext = countNow;
            destNext    = destNow;
            typeNext    = typeNow;
            opcodeNext  = opcodeNow;
            // stop at two so the header stays captured
            if (curBeat != 2'h2) begin
                beatIdxNext = curBeat + 2'h1;
            end else begin
                beatIdxNext = curBeat;
            end
        end
    end

    // frame tracking registers
    // async reset puts the tracker back to idle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // constants only in the reset branch
            stateReg   <= ST_IDLE;
            byteCntReg <= '0;
            beatIdxReg <= 2'h0;
            destReg    <= 48'h0;
            typeReg    <= 16'h0000;
            opcodeReg  <= 16'h0000;
        end else begin
            // plain copy of the next values
            stateReg   <= stateNext;
            byteCntReg <= byteCntNext;
            beatIdxReg <= beatIdxNext;
            destReg    <= destNext;
            typeReg    <= typeNext;
            opcodeReg  <= opcodeNext;
        end
    end

    // classify the frame from its final count and header
    // the live view is used, so a frame that ends
    // in this beat is judged in this beat
    frame_classifier classifier (
        .destAddr   (destNow),
        .lenType    (typeNow),
        .ctrlOpcode (opcodeNow),
        .frameBytes (countNow),
        .fcsBad     (rxFcsBad),
        .classHits  (classHits)
    );

    // the legal length error class lives here, beside the other
    // length checks that the classifier already makes
    // both bounds are inclusive
    always_comb begin
        legalBadHit = rxFcsBad
                      && (countNow >= `MIN_FRAME_BYTES)
                      && (countNow <= `MAX_FRAME_BYTES);              // R13
    end

    // requests fire only on the last beat, so each class gets at most
    // one pulse per frame; the fcs request is raised in the cycle the
    // error is reported, with no regard for any client side filter
    // the eop mask is the only gate on the requests
    always_comb begin
        fireVec = classHits & {`PULSE_COUNT{frameEnd}};               // R17 R9 R10
    end

    // one registered stage per class, all on the receive mac clock
    // each stage adds the one cycle of latency
    for (genvar i = 0; i < `PULSE_COUNT; i++) begin : g_pulse
        pulse_stage stage (
            .ref_clk (ref_clk),                                       // R16
            .rst     (rst),
            .fire    (fireVec[i]),
            .pulse   (pulseVec[i])
        );
    end

    // separate stage for the legal length error class
    // keeps the class vector at ten bits
    pulse_stage legal_bad_stage (
        .ref_clk (ref_clk),
        .rst     (rst),
        .fire    (legalBadHit && frameEnd),                           // R13
        .pulse   (rx_legal_length_bad_checksum_pulse)
    );

    // every pulse leaves on its own port unconditionally; the same
    // wires serve as counter increments where counters are built
    // data classes
    assign bcastDataGoodPulse = pulseVec[`P_BCAST_DATA_OK];           // R1 R14 R15
    assign ucastDataBadPulse  = pulseVec[`P_UCAST_DATA_ERR];          // R2
    assign ucastDataGoodPulse = pulseVec[`P_UCAST_DATA_OK];           // R3
    // good frames by destination
    assign mcastAnyGoodPulse  = pulseVec[`P_MCAST_CTRL];              // R4
    assign bcastAnyGoodPulse  = pulseVec[`P_BCAST_CTRL];              // R5
    assign ucastAnyGoodPulse  = pulseVec[`P_UCAST_CTRL];              // R6
    // control frames
    assign pauseGoodPulse     = pulseVec[`P_PAUSE];                   // R7
    // error and length classes
    assign checksumBadPulse   = pulseVec[`P_FCS_ERR];                 // R8
    assign fragmentPulse      = pulseVec[`P_FRAGMENT];                // R11
    assign jabberPulse        = pulseVec[`P_JABBER];                  // R12

endmodule // rx_statistics_increment_pulses

// ---- rx_stat_consts.svh ----
/*
  Constants for the receive statistics increment pulse block: stream
  geometry, frame length limits, control frame codes and pulse positions.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef RX_STAT_CONSTS_SVH
`define RX_STAT_CONSTS_SVH

// stream geometry: eight bytes per beat, first byte in the top lane
`define BEAT_BYTES       4'h8
`define EMPTY_W          3
`define CNT_W            16
`define CNT_SAT          16'hffff

// frame length limits in bytes, counted from destination address to fcs
`define MIN_FRAME_BYTES  16'h0040
`define MAX_FRAME_BYTES  16'h05ee

// mac control frame codes
`define CTRL_TYPE        16'h8808
`define PAUSE_OPCODE     16'h0001

// bit positions in the pulse vector
`define PULSE_COUNT      10
`define P_BCAST_DATA_OK  0
`define P_UCAST_DATA_ERR 1
`define P_UCAST_DATA_OK  2
`define P_MCAST_CTRL     3
`define P_BCAST_CTRL     4
`define P_UCAST_CTRL     5
`define P_PAUSE          6
`define P_FCS_ERR        7
`define P_FRAGMENT       8
`define P_JABBER         9

`endif

// ---- rx_stat_pkg.sv ----
/*
  Types shared by the receive statistics increment pulse block.
  Assumes the constants header is on the include path.
*/
`include "rx_stat_consts.svh"

package rx_stat_pkg;

    // frame tracking states
    typedef enum logic {
        ST_IDLE,
        ST_FRAME
    } rx_state_t;

    // one bit per statistics class
    typedef logic [`PULSE_COUNT-1:0] pulse_vec_t;

    // byte count of a frame
    typedef logic [`CNT_W-1:0] byte_cnt_t;

endpackage

// ---- pulse_stage.sv ----
/*
  One registered increment pulse: the output is high in the cycle after
  a fire request and low otherwise.
  Assumes fire is a one-cycle request on the same clock.
*/
`timescale 1ns/1ps

module pulse_stage (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic fire,
    output logic      pulse
);

    logic pulseNext; // next output level

    // a pulse lasts exactly one cycle per request
    always_comb begin
        pulseNext = fire;
    end

    // held low while reset is asserted
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pulse <= 1'b0;
        end else begin
            pulse <= pulseNext;
        end
    end

endmodule // pulse_stage

// ---- frame_classifier.sv ----
/*
  Combinational classifier of one finished receive frame: destination
  kind, control or data, pause, length class and fcs result.
  Assumes all inputs describe the same frame and are stable together.
*/
`timescale 1ns/1ps

module frame_classifier
    import rx_stat_pkg::*;
(
    input  wire logic [47:0] destAddr,
    input  wire logic [15:0] lenType,
    input  wire logic [15:0] ctrlOpcode,
    input  wire byte_cnt_t   frameBytes,
    input  wire logic        fcsBad,
    output pulse_vec_t       classHits
);

    logic isBcast;   // all ones destination
    logic isMcast;   // group bit set, not broadcast
    logic isUcast;   // group bit clear
    logic isCtrl;    // mac control frame
    logic isShort;   // under the minimum size
    logic isLong;    // over the maximum size
    logic isGood;    // fcs clean and legal length

    // the group bit is the first bit on the wire of the first byte
    always_comb begin
        isBcast = &destAddr;
        isMcast = destAddr[40] && !isBcast;
        isUcast = !destAddr[40];
        isCtrl  = (lenType == `CTRL_TYPE);
        isShort = (frameBytes < `MIN_FRAME_BYTES);
        isLong  = (frameBytes > `MAX_FRAME_BYTES);
        isGood  = !fcsBad && !isShort && !isLong;
        classHits = '0;
        classHits[`P_BCAST_DATA_OK]  = isGood && isBcast && !isCtrl;             // R1
        classHits[`P_UCAST_DATA_ERR] = fcsBad && isUcast && !isCtrl;             // R2
        classHits[`P_UCAST_DATA_OK]  = isGood && isUcast && !isCtrl;             // R3
        classHits[`P_MCAST_CTRL]     = isGood && isMcast;                        // R4
        classHits[`P_BCAST_CTRL]     = isGood && isBcast;                        // R5
        classHits[`P_UCAST_CTRL]     = isGood && isUcast;                        // R6
        classHits[`P_PAUSE]          = isGood && isCtrl
                                       && (ctrlOpcode == `PAUSE_OPCODE);         // R7
        classHits[`P_FCS_ERR]        = fcsBad;                                   // R8
        classHits[`P_FRAGMENT]       = fcsBad && isShort;                        // R11
        classHits[`P_JABBER]         = fcsBad && isLong;                         // R12
    end

endmodule // frame_classifier

// ---- rx_stat_counter_model.sv ----
/*
  Counter model: stands in for the statistics counters fed by the pulses.
  Assumes the pulses are sampled on ref_clk and rst clears the counts.
*/
`timescale 1ns/1ps

module rx_stat_counter_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [10:0] incPulses,
    output logic      [15:0] classCount_reg [11]
);
    logic [15:0] classCount_next [11]; // next count per class

    // each high cycle is one increment, so a stuck pulse shows as extra counts
    always_comb begin
        for (int i = 0; i < 11; i++) classCount_next[i] = classCount_reg[i] + 16'(incPulses[i]);
    end

    // only registers; sampled on the receive mac clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 11; i++) classCount_reg[i] <= 16'h0;
        end else begin
            classCount_reg <= classCount_next;
        end
    end
endmodule // rx_stat_counter_model

// ---- rx_statistics_increment_pulses_properties.sv ----
/*
  Checker for pulse timing and class relations at the block ports.
  Assumes it is bound to the top module; one clock, async reset.
*/
`timescale 1ns/1ps
`include "rx_stat_consts.svh"

module rx_stat_pulse_checker (
    input wire logic                ref_clk,
    input wire logic                rst,
    input wire logic                rxValid,
    input wire logic                rxSop,
    input wire logic                rxEop,
    input wire logic [63:0]         rxData,
    input wire logic [`EMPTY_W-1:0] rxEmpty,
    input wire logic                rxFcsBad,
    input wire logic                bcastDataGoodPulse,
    input wire logic                ucastDataBadPulse,
    input wire logic                ucastDataGoodPulse,
    input wire logic                mcastAnyGoodPulse,
    input wire logic                bcastAnyGoodPulse,
    input wire logic                ucastAnyGoodPulse,
    input wire logic                pauseGoodPulse,
    input wire logic                checksumBadPulse,
    input wire logic                fragmentPulse,
    input wire logic                jabberPulse,
    input wire logic                rx_legal_length_bad_checksum_pulse
);
    logic        openReg;   // a frame is in progress
    logic        openNext;  // next frame-open state
    logic        endTaken;  // eop beat of an open or starting frame
    logic [10:0] allPulses; // all outputs, good classes in mask 07d

    assign allPulses = {rx_legal_length_bad_checksum_pulse, jabberPulse, fragmentPulse, checksumBadPulse,
                        pauseGoodPulse, ucastAnyGoodPulse, bcastAnyGoodPulse, mcastAnyGoodPulse,
                        ucastDataGoodPulse, ucastDataBadPulse, bcastDataGoodPulse};
    assign endTaken = rxValid && rxEop && (rxSop || openReg);

    // stray beats without a start never open a frame
    always_comb begin
        openNext = openReg;
        if (rxValid) openNext = !rxEop && (rxSop || openReg);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) openReg <= 1'b0;
        else openReg <= openNext;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_reset_low: assert property (disable iff (1'b0) rst |-> allPulses == 11'h0)
        else $error("pulse while in reset");
    chk_quiet_no_end: assert property (!endTaken |=> allPulses == 11'h0)
        else $error("pulse without a frame end");
    chk_fcs_follows: assert property (endTaken |=> checksumBadPulse == $past(rxFcsBad))
        else $error("fcs pulse does not follow eop flag");
    chk_good_bad_apart: assert property (checksumBadPulse |-> (allPulses & 11'h07d) == 11'h0)
        else $error("good class pulse on bad frame");
    chk_length_onehot: assert property (checksumBadPulse |-> $onehot(allPulses[10:8]))
        else $error("bad frame not in exactly one length class");
    chk_class_needs_fcs: assert property (|{allPulses[10:8], ucastDataBadPulse} |-> checksumBadPulse)
        else $error("error class pulse without fcs pulse");
    chk_dest_onehot: assert property ($onehot0(allPulses[5:3]))
        else $error("more than one destination class");
    chk_bcast_data: assert property (bcastDataGoodPulse |-> bcastAnyGoodPulse)
        else $error("broadcast data without broadcast any");
    chk_ucast_data: assert property (ucastDataGoodPulse |-> ucastAnyGoodPulse)
        else $error("unicast data without unicast any");
    chk_single_beat: assert property (endTaken && rxSop && rxFcsBad |=> fragmentPulse)
        else $error("short bad frame missed fragment");
    chk_pause_ctrl: assert property (pauseGoodPulse |-> !bcastDataGoodPulse && !ucastDataGoodPulse)
        else $error("pause counted as data");

    cov_bad_end: cover property (endTaken && rxFcsBad);
    cov_pause: cover property (pauseGoodPulse);
    cov_jabber: cover property (jabberPulse);
endmodule // rx_stat_pulse_checker

bind rx_statistics_increment_pulses rx_stat_pulse_checker chk_u (.ref_clk, .rst, .rxValid, .rxSop, .rxEop,
    .rxData, .rxEmpty, .rxFcsBad, .bcastDataGoodPulse, .ucastDataBadPulse, .ucastDataGoodPulse,
    .mcastAnyGoodPulse, .bcastAnyGoodPulse, .ucastAnyGoodPulse, .pauseGoodPulse, .checksumBadPulse,
    .fragmentPulse, .jabberPulse, .rx_legal_length_bad_checksum_pulse);

// ---- testbench.sv ----
/*
  Testbench: sends frames into the pulse block and compares class counts
  kept by the counter model against counts worked out here.
  Assumes the package, constants header, checker and model are compiled.
*/
`timescale 1ns/1ps
`include "rx_stat_consts.svh"

module testbench;
    logic                ref_clk = 1'b1;  // first edge is a falling one
    logic                rst = 1'b0;      // raised at that falling edge
    logic                rxValid = 1'b0;
    logic                rxSop = 1'b0;
    logic                rxEop = 1'b0;
    logic                rxFcsBad = 1'b0;
    logic [63:0]         rxData = 64'h0;
    logic [`EMPTY_W-1:0] rxEmpty = 3'h0;
    wire logic [10:0]    pulses;          // bit 0 broadcast data good ... bit 10 legal length bad
    logic [15:0]         counts [11];     // model counts per class
    logic [15:0]         base [11];       // counts at scenario start
    int                  expc [11];       // expected increments
    int                  err_count = 0;
    int                  checked = 0;
    localparam logic [47:0] BC = 48'hffff_ffff_ffff;
    localparam logic [47:0] UC = 48'h0200_0000_0001;
    localparam logic [47:0] MC = 48'h0100_5e00_0001;

    always #12.5 ref_clk = ~ref_clk;

    rx_statistics_increment_pulses dut_u (.ref_clk, .rst, .rxValid, .rxSop, .rxEop, .rxData, .rxEmpty, .rxFcsBad,
        .bcastDataGoodPulse(pulses[0]), .ucastDataBadPulse(pulses[1]), .ucastDataGoodPulse(pulses[2]),
        .mcastAnyGoodPulse(pulses[3]), .bcastAnyGoodPulse(pulses[4]), .ucastAnyGoodPulse(pulses[5]),
        .pauseGoodPulse(pulses[6]), .checksumBadPulse(pulses[7]), .fragmentPulse(pulses[8]),
        .jabberPulse(pulses[9]), .rx_legal_length_bad_checksum_pulse(pulses[10]));
    rx_stat_counter_model cm_u (.ref_clk, .rst, .incPulses(pulses), .classCount_reg(counts));

    task automatic fail(input string msg);
        err_count++;
        $display("Error at %0t: %s", $time, msg);
    endtask

    // expected classes of one frame; only lengths up to 8 or from 14 are used
    function automatic logic [10:0] exp_vec(input logic [47:0] d, input logic [15:0] ty, op, input int n,
                                            input bit bad);
        bit good, bc, uc, ct;
        good = !bad && n >= 64 && n <= 1518;
        bc = d === BC;
        uc = !d[40];
        ct = n > 13 && ty === `CTRL_TYPE;
        return {bad && n >= 64 && n <= 1518, bad && n > 1518, bad && n < 64, bad,
                good && ct && op === `PAUSE_OPCODE, good && uc, good && bc, good && d[40] && !bc,
                good && uc && !ct, bad && uc && !ct, good && bc && !ct};
    endfunction

    task automatic beat(input bit s, e, input logic [63:0] d, input int emp, input bit bad);
        @(negedge ref_clk);
        rxValid = 1'b1;
        rxSop = s;
        rxEop = e;
        rxData = d;
        rxEmpty = 3'(emp);
        rxFcsBad = bad;
    endtask

    // idle data is inverted so a stale beat never looks valid
    task automatic idle(input int k);
        @(negedge ref_clk);
        rxValid = 1'b0;
        rxSop = 1'b0;
        rxEop = 1'b0;
        rxData = ~rxData;
        repeat (k) @(negedge ref_clk);
    endtask

    task automatic frame(input logic [47:0] d, input logic [15:0] ty, op, input int n, input bit bad);
        int nb;
        logic [10:0] v;
        nb = (n + 7) / 8;
        v = exp_vec(d, ty, op, n, bad);
        for (int i = 0; i < 11; i++) expc[i] += v[i];
        for (int b = 0; b < nb; b++)
            beat(b == 0, b == nb - 1, b == 0 ? {d, 16'h5a5a} : b == 1 ? {32'h0, ty, op} : {8'(b), 56'h0},
                 nb * 8 - n, bad && b == nb - 1);
    endtask

    task automatic start();
        for (int i = 0; i < 11; i++) begin
            base[i] = counts[i];
            expc[i] = 0;
        end
    endtask

    task automatic check_counts(input string what);
        idle(3);
        for (int i = 0; i < 11; i++) begin
            checked++;
            if (counts[i] !== base[i] + 16'(expc[i])) fail($sformatf("%s class %0d got %0d", what, i, counts[i]));
        end
    endtask

    // back-to-back frames of each destination kind
    task automatic test_dest();
        start();
        frame(BC, 16'h0800, 16'h0, 64, 1'b0);
        frame(UC, 16'h0800, 16'h0, 100, 1'b0);
        frame(MC, 16'h0800, 16'h0, 1518, 1'b0);
        frame(UC, 16'h0800, 16'h0, 200, 1'b1);
        check_counts("dest");
    endtask

    task automatic test_ctrl();
        start();
        frame(UC, `CTRL_TYPE, `PAUSE_OPCODE, 64, 1'b0);
        frame(BC, `CTRL_TYPE, 16'h0002, 80, 1'b0);
        frame(MC, `CTRL_TYPE, `PAUSE_OPCODE, 64, 1'b0);
        frame(UC, `CTRL_TYPE, `PAUSE_OPCODE, 64, 1'b1);
        check_counts("ctrl");
    endtask

    // length boundaries around 64 and 1518 bytes
    task automatic test_len();
        start();
        frame(UC, 16'h0, 16'h0, 8, 1'b1);
        frame(UC, 16'h0800, 16'h0, 63, 1'b1);
        frame(UC, 16'h0800, 16'h0, 64, 1'b1);
        frame(MC, 16'h0800, 16'h0, 1518, 1'b1);
        frame(BC, 16'h0800, 16'h0, 1519, 1'b1);
        frame(UC, 16'h0800, 16'h0, 1519, 1'b0);
        frame(UC, 16'h0800, 16'h0, 63, 1'b0);
        check_counts("len");
    endtask

    // stray eop is ignored, a new start abandons the open frame
    task automatic test_stream();
        start();
        beat(1'b0, 1'b1, {BC, 16'h0}, 0, 1'b1);
        idle(1);
        beat(1'b1, 1'b0, {UC, 16'h0}, 0, 1'b0);
        beat(1'b0, 1'b0, 64'h0, 0, 1'b0);
        frame(BC, 16'h0800, 16'h0, 72, 1'b0);
        check_counts("stream");
    endtask

    task automatic test_reset();
        beat(1'b1, 1'b0, {UC, 16'h0}, 0, 1'b0);
        @(negedge ref_clk);
        rst = 1'b1;
        rxValid = 1'b0;
        for (int i = 0; i < 2; i++) begin
            @(negedge ref_clk);
            checked++;
            if (pulses !== 11'h0) fail("pulse during reset");
        end
        rst = 1'b0;
        start();
        beat(1'b0, 1'b1, 64'h0, 0, 1'b1);
        frame(BC, 16'h0800, 16'h0, 64, 1'b0);
        check_counts("reset");
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        // a real rising reset edge clears the flops before the first clock
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        test_dest();
        test_ctrl();
        test_len();
        test_stream();
        test_reset();
        finish_test();
    end

    // watchdog against a stuck run
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail("timeout");
        finish_test();
    end
endmodule // testbench
